/* inc/obr_pkg.sv */
package obr_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_READOUT_LOCK = 8'h00;
    localparam logic [7:0] ADDR_BOOT_AREA    = 8'h04;
    localparam logic [7:0] ADDR_PIN_REMAP    = 8'h08;
    localparam logic [7:0] ADDR_PERIPH_EN    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS       = 8'h10;
    localparam logic [7:0] ADDR_RELOAD       = 8'h14;

    // ****************************************
    // Reset values of stored option bytes
    // ****************************************
    localparam logic [7:0] RST_READOUT_LOCK = 8'h00;
    localparam logic [7:0] RST_BOOT_AREA    = 8'h00;
    localparam logic [7:0] RST_PIN_REMAP    = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN    = 8'h00;

    // ****************************************
    // Option byte encodings
    // ****************************************
    localparam logic [7:0] READOUT_LOCK_ON  = 8'hAA;
    localparam logic [7:0] BOOT_AREA_NONE   = 8'h00;
    localparam logic [7:0] BOOT_AREA_RSVD   = 8'hFF;

    // ****************************************
    // Remap bit positions
    // ****************************************
    localparam int REMAP_BIT_2 = 2;
    localparam int REMAP_BIT_3 = 3;
    localparam int REMAP_BIT_4 = 4;
    localparam int REMAP_BIT_5 = 5;
    localparam int REMAP_BIT_6 = 6;
    localparam int REMAP_BIT_7 = 7;

    // ****************************************
    // Peripheral enable bit positions
    // ****************************************
    localparam int PEN_TIMER_B   = 0;
    localparam int PEN_BEEPER    = 1;
    localparam int PEN_ANALOG    = 2;
    localparam int PEN_I2C       = 3;
    localparam int PEN_ADV_TIMER = 4;
    localparam int PEN_CLK_OUT   = 5;
    localparam int PEN_ALT_D0    = 6;

    // ****************************************
    // Status bit positions
    // ****************************************
    localparam int ST_READOUT_LOCKED = 0;
    localparam int ST_BOOT_AREA_ON   = 1;
    localparam int ST_BOOT_AREA_RSVD = 2;
    localparam int ST_LOADED         = 3;

    typedef enum logic [1:0] {
        OBR_LOAD = 2'b01,
        OBR_RUN  = 2'b10
    } obr_state_t;

endpackage

/* rtl/obr_option_decode.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Readout lock byte 0xAA enables protection
// - Boot area byte 0x00: no protection
// - Boot byte other than 0x00 or 0xFF protects pages from zero
// - Bit 7 picks timer B or beeper
// - Bit 6 picks analog or I2C lines
// - Bit 5 picks analog or advanced timer
// - Bit 4 clear routes advanced channel four
// - Remap bit sets clock output on D0
// - Bit 2 wins over bit 3
// - Active remap removes default function
// - Function needs its peripheral enabled too
// - Remap leaves GPIO capability untouched
module obr_option_decode (
    input  wire logic        pclk,            // APB clock
    input  wire logic        presetn,         // Async reset, low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error
    output logic             readout_protect, // Readout lock active
    output logic             debug_write_ok,  // Debug writes allowed
    output logic             boot_area_en,    // Boot area defined
    output logic      [8:0]  boot_last_page,  // Last protected page
    output logic      [7:0]  pd4_af_sel,      // D4: 1=timer B,2=beeper
    output logic      [7:0]  pb5_pb4_af_sel,  // B5/B4: 1=analog,2=I2C
    output logic      [7:0]  pb3_pb0_af_sel,  // B3..0: 1=analog,2=tmr
    output logic      [7:0]  pd7_af_sel,      // D7: 1=adv ch4
    output logic      [7:0]  pd0_af_sel,      // D0: 1=alt,2=clk out
    output logic             gpio_keep        // GPIO always usable
);

    // ****************************************
    // Option storage (non-volatile image)
    // ****************************************
    logic [7:0] opt_r [3];
    logic [7:0] periph_en_r;
    logic       reload_r;

    // Latched copies used by the decode
    logic [7:0] lock_r;
    logic [7:0] boot_r;
    logic [7:0] remap_r;
    logic       loaded_r;
    obr_pkg::obr_state_t state_r;
    obr_pkg::obr_state_t state_nxt;

    logic        wr_en;
    logic        addr_ok;
    logic [31:0] rd_nxt;

    // Index of an option byte register, 3 when not one
    function automatic logic [1:0] opt_index(input logic [7:0] a);
        case (a)
            obr_pkg::ADDR_READOUT_LOCK: opt_index = 2'd0;
            obr_pkg::ADDR_BOOT_AREA:    opt_index = 2'd1;
            obr_pkg::ADDR_PIN_REMAP:    opt_index = 2'd2;
            default:                    opt_index = 2'd3;
        endcase
    endfunction

    // Pin select code gated by its peripheral enable
    function automatic logic [7:0] af_code(input logic en,
                                            input logic [7:0] code);
        af_code = en ? code : 8'h00;
    endfunction

    // ****************************************
    // APB slave
    // ****************************************
    assign wr_en   = psel & penable & pwrite;
    assign addr_ok = (opt_index(paddr) != 2'd3)
                   || (paddr == obr_pkg::ADDR_PERIPH_EN)
                   || (paddr == obr_pkg::ADDR_STATUS)
                   || (paddr == obr_pkg::ADDR_RELOAD);

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (opt_index(paddr) != 2'd3) begin
            rd_nxt[7:0] = opt_r[opt_index(paddr)];
        end else if (paddr == obr_pkg::ADDR_PERIPH_EN) begin
            rd_nxt[7:0] = periph_en_r;
        end else if (paddr == obr_pkg::ADDR_STATUS) begin
            rd_nxt[obr_pkg::ST_READOUT_LOCKED] = readout_protect;
            rd_nxt[obr_pkg::ST_BOOT_AREA_ON]   = boot_area_en;
            rd_nxt[obr_pkg::ST_BOOT_AREA_RSVD] =
                (boot_r == obr_pkg::BOOT_AREA_RSVD);
            rd_nxt[obr_pkg::ST_LOADED]         = loaded_r;
        end
    end

    // Zero wait state: ready goes high in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // Error flag rides with the ready pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~addr_ok;
        end
    end

    // Read data stands only while ready is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    logic wr_hit;

    // Writes land in the access cycle, pready already high
    assign wr_hit = wr_en & pready & addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_r[0] <= obr_pkg::RST_READOUT_LOCK;
            opt_r[1] <= obr_pkg::RST_BOOT_AREA;
            opt_r[2] <= obr_pkg::RST_PIN_REMAP;
        end else if (wr_hit && opt_index(paddr) != 2'd3) begin
            opt_r[opt_index(paddr)] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_en_r <= obr_pkg::RST_PERIPH_EN;
        end else if (wr_hit && paddr == obr_pkg::ADDR_PERIPH_EN) begin
            periph_en_r <= pwdata[7:0];
        end
    end

    // One-cycle pulse, so a held bus cannot reload twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= 1'b0;
        end else begin
            reload_r <= wr_hit && (paddr == obr_pkg::ADDR_RELOAD)
                        && pwdata[0];
        end
    end

    // ****************************************
    // Option load sequencer
    // ****************************************
    // load then hold
    always_comb begin
        case (state_r)
            obr_pkg::OBR_LOAD: state_nxt = obr_pkg::OBR_RUN;
            obr_pkg::OBR_RUN:
                state_nxt = reload_r ? obr_pkg::OBR_LOAD : obr_pkg::OBR_RUN;
            default:           state_nxt = obr_pkg::OBR_LOAD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= obr_pkg::OBR_LOAD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Latches change only in the load state, never mid-run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r   <= obr_pkg::RST_READOUT_LOCK;
            boot_r   <= obr_pkg::RST_BOOT_AREA;
            remap_r  <= obr_pkg::RST_PIN_REMAP;
            loaded_r <= 1'b0;
        end else if (state_r == obr_pkg::OBR_LOAD) begin
            lock_r   <= opt_r[0];
            boot_r   <= opt_r[1];
            remap_r  <= opt_r[2];
            loaded_r <= 1'b1;
        end
    end

    // ****************************************
    // Protection decode
    // ****************************************
    logic       protect_nxt;
    logic       boot_en_nxt;
    logic [8:0] last_page_nxt;

    assign protect_nxt = loaded_r && (lock_r == obr_pkg::READOUT_LOCK_ON);

    // reserved code treated as no area, flagged
    assign boot_en_nxt = loaded_r
                       && (boot_r != obr_pkg::BOOT_AREA_NONE)
                       && (boot_r != obr_pkg::BOOT_AREA_RSVD);

    // pages 0..N+1, 0x01 and 0x02 end at 2N-1
    always_comb begin
        if (!boot_en_nxt) begin
            last_page_nxt = 9'h000;
        end else if (boot_r == 8'h01 || boot_r == 8'h02) begin
            last_page_nxt = {boot_r, 1'b0} - 9'h001;
        end else begin
            last_page_nxt = {1'b0, boot_r} + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            readout_protect <= 1'b0;
        end else begin
            readout_protect <= protect_nxt;
        end
    end

    // Debug writes stay open even while locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_write_ok <= 1'b1;
        end else begin
            debug_write_ok <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_area_en <= 1'b0;
        end else begin
            boot_area_en <= boot_en_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_last_page <= 9'h000;
        end else begin
            boot_last_page <= last_page_nxt;
        end
    end

    // ****************************************
    // Pin function selection
    // ****************************************
    logic [7:0] d4_nxt;
    logic [7:0] b54_nxt;
    logic [7:0] b30_nxt;
    logic [7:0] d7_nxt;
    logic [7:0] d0_nxt;

    assign d4_nxt = remap_r[obr_pkg::REMAP_BIT_7]
                  ? af_code(periph_en_r[obr_pkg::PEN_BEEPER], 8'h02)
                  : af_code(periph_en_r[obr_pkg::PEN_TIMER_B], 8'h01);

    assign b54_nxt = remap_r[obr_pkg::REMAP_BIT_6]
                   ? af_code(periph_en_r[obr_pkg::PEN_I2C], 8'h02)
                   : af_code(periph_en_r[obr_pkg::PEN_ANALOG], 8'h01);

    assign b30_nxt = remap_r[obr_pkg::REMAP_BIT_5]
                   ? af_code(periph_en_r[obr_pkg::PEN_ADV_TIMER], 8'h02)
                   : af_code(periph_en_r[obr_pkg::PEN_ANALOG], 8'h01);

    assign d7_nxt = remap_r[obr_pkg::REMAP_BIT_4]
                  ? 8'h00
                  : af_code(periph_en_r[obr_pkg::PEN_ADV_TIMER], 8'h01);

    always_comb begin
        if (remap_r[obr_pkg::REMAP_BIT_2]) begin
            d0_nxt = af_code(periph_en_r[obr_pkg::PEN_CLK_OUT], 8'h02);
        end else if (remap_r[obr_pkg::REMAP_BIT_3]) begin
            d0_nxt = af_code(periph_en_r[obr_pkg::PEN_CLK_OUT], 8'h02);
        end else begin
            d0_nxt = af_code(periph_en_r[obr_pkg::PEN_ALT_D0], 8'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd4_af_sel <= 8'h00;
        end else begin
            pd4_af_sel <= d4_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb5_pb4_af_sel <= 8'h00;
        end else begin
            pb5_pb4_af_sel <= b54_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb3_pb0_af_sel <= 8'h00;
        end else begin
            pb3_pb0_af_sel <= b30_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd7_af_sel <= 8'h00;
        end else begin
            pd7_af_sel <= d7_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd0_af_sel <= 8'h00;
        end else begin
            pd0_af_sel <= d0_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_keep <= 1'b1;
        end else begin
            gpio_keep <= 1'b1;
        end
    end

endmodule

/* verification/obr_option_decode_sva.sv */
`timescale 1ns/1ps
module obr_option_decode_sva (
    input wire logic        pclk,            // Clock
    input wire logic        presetn,         // Reset, low
    input wire logic        psel,            // Select
    input wire logic        penable,         // Enable
    input wire logic        pwrite,          // Direction
    input wire logic [7:0]  paddr,           // Address
    input wire logic [31:0] pwdata,          // Write data
    input wire logic [31:0] prdata,          // Read data
    input wire logic        pready,          // Ready
    input wire logic        pslverr,         // Error
    input wire logic        readout_protect, // Lock
    input wire logic        debug_write_ok,  // Debug ok
    input wire logic        boot_area_en,    // Boot area
    input wire logic [8:0]  boot_last_page,  // Last page
    input wire logic [7:0]  pd4_af_sel,      // D4
    input wire logic [7:0]  pb5_pb4_af_sel,  // B5/B4
    input wire logic [7:0]  pb3_pb0_af_sel,  // B3..B0
    input wire logic [7:0]  pd7_af_sel,      // D7
    input wire logic [7:0]  pd0_af_sel,      // D0
    input wire logic        gpio_keep        // GPIO
);
    logic       decode_hit;
    logic [2:0] quiet_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Enable writes move pin selects at once, so they restart the count
    assign decode_hit = psel & penable & pready & pwrite
                        & (((paddr == obr_pkg::ADDR_RELOAD) & pwdata[0])
                           | (paddr == obr_pkg::ADDR_PERIPH_EN));
    // Cycles since last reload or enable write, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_r <= 3'h0;
        end else if (decode_hit) begin
            quiet_r <= 3'h0;
        end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    a_ready_answer: assert property (setup_s |=> access_s ##1 !pready)
        else $error("pready not one cycle after setup");
    a_err_unmapped: assert property (access_s and
        paddr > obr_pkg::ADDR_RELOAD |-> pslverr)
        else $error("no error on unmapped address");
    a_read_upper: assert property (access_s and !pwrite |->
        prdata[31:8] == 24'h0) else $error("upper read bits set");
    a_debug_kept: assert property (debug_write_ok)
        else $error("debug writes blocked");
    a_gpio_kept: assert property (gpio_keep)
        else $error("gpio capability dropped");
    a_boot_none: assert property (
        !boot_area_en |-> boot_last_page == 9'h0)
        else $error("page set without boot area");
    a_boot_area: assert property (boot_area_en |-> boot_last_page != 9'h0)
        else $error("boot area with no page");
    a_d0_codes: assert property (pd0_af_sel <= 8'h02 && pd7_af_sel <= 8'h01)
        else $error("bad select code");
    a_hold_decode: assert property (
        quiet_r == 3'h7 && $past(quiet_r) == 3'h7
        |-> $stable({readout_protect, boot_area_en, boot_last_page,
        pd4_af_sel, pb5_pb4_af_sel, pb3_pb0_af_sel, pd7_af_sel,
        pd0_af_sel}))
        else $error("decode changed without reload");
endmodule
bind obr_option_decode obr_option_decode_sva chk (.*);

/* verification/option_byte_remap_protect_tb_top.sv */
`timescale 1ns/1ps
module option_byte_remap_protect_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        readout_protect, debug_write_ok, boot_area_en, gpio_keep;
    logic [7:0]  paddr, pd4_af_sel, pb5_pb4_af_sel, pb3_pb0_af_sel;
    logic [7:0]  pd7_af_sel, pd0_af_sel;
    logic [8:0]  boot_last_page;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    int          errors;
    int          check_count;

    obr_option_decode dut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .readout_protect (readout_protect),
        .debug_write_ok  (debug_write_ok),
        .boot_area_en    (boot_area_en),
        .boot_last_page  (boot_last_page),
        .pd4_af_sel      (pd4_af_sel),
        .pb5_pb4_af_sel  (pb5_pb4_af_sel),
        .pb3_pb0_af_sel  (pb3_pb0_af_sel),
        .pd7_af_sel      (pd7_af_sel),
        .pd0_af_sel      (pd0_af_sel),
        .gpio_keep       (gpio_keep)
    );

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask

    // Bounded wait: a missing pready ends the run
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        errors++;
        complete_run();
    endtask

    task automatic cfg(input logic [7:0] l, b, m, e);
        apb(1'b1, obr_pkg::ADDR_READOUT_LOCK, {24'h0, l});
        apb(1'b1, obr_pkg::ADDR_BOOT_AREA, {24'h0, b});
        apb(1'b1, obr_pkg::ADDR_PIN_REMAP, {24'h0, m});
        apb(1'b1, obr_pkg::ADDR_PERIPH_EN, {24'h0, e});
        apb(1'b1, obr_pkg::ADDR_RELOAD, 32'h1);
        repeat (4) @(posedge pclk);
    endtask

    task automatic expect_out(input logic rp, en, input logic [8:0] pg,
                              input logic [7:0] d4, b54, b30, d7, d0);
        check("readout_protect", readout_protect, rp);
        check("boot_area_en", boot_area_en, en);
        check("boot_last_page", boot_last_page, pg);
        check("pd4_af_sel", pd4_af_sel, d4);
        check("pb5_pb4_af_sel", pb5_pb4_af_sel, b54);
        check("pb3_pb0_af_sel", pb3_pb0_af_sel, b30);
        check("pd7_af_sel", pd7_af_sel, d7);
        check("pd0_af_sel", pd0_af_sel, d0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        errors = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check("debug_write_ok", debug_write_ok, 32'h1);
        check("gpio_keep", gpio_keep, 32'h1);
        expect_out(0, 0, 0, 0, 0, 0, 0, 0);
        cfg(8'hAA, 8'h01, 8'h00, 8'h7F);
        expect_out(1, 1, 1, 1, 1, 1, 1, 1);
        cfg(8'h00, 8'h00, 8'hFC, 8'h7F);
        expect_out(0, 0, 0, 2, 2, 2, 0, 2);
        cfg(8'h55, 8'hFE, 8'h04, 8'h7F);
        expect_out(0, 1, 255, 1, 1, 1, 1, 2);
        cfg(8'h00, 8'h03, 8'h08, 8'h02);
        expect_out(0, 1, 4, 0, 0, 0, 0, 0);
        // Boot byte stays off the reserved code
        cfg(8'hAA, 8'h02, 8'h80, 8'h02);
        expect_out(1, 1, 3, 2, 0, 0, 0, 0);
        apb(1'b0, obr_pkg::ADDR_STATUS, 32'h0);
        check("status", rd, 32'h0000000B);
        apb(1'b1, obr_pkg::ADDR_READOUT_LOCK, 32'h0);
        repeat (4) @(posedge pclk);
        check("held lock", readout_protect, 32'h1);
        apb(1'b0, obr_pkg::ADDR_READOUT_LOCK, 32'h0);
        check("lock readback", rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped err", err, 32'h1);
        check("unmapped data", rd, 32'h0);
        complete_run();
    end
endmodule
